// ===== logic/asu_uart.sv
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/10ps
// Notes on behaviour
// - Receive line is deserialized into words; written words are serialized out.
// - Fractional divider off reference clock; top rate ref/16, or ref/8 fast.
// - Data length five to eight bits, same at both ends.
// - Parity even, odd, stick or none, generated and checked.
// - One or two stop bits; one and a half not offered.
// - Partner's pause and resume characters halt and restart transmission.
// - A start edge not low at mid bit is dropped, no character built.
// - Break driven on command; incoming break detected and flagged.
// - Transmit queue of 64 eight-bit entries, separate from receive.
// - Receive queue of 64 twelve-bit entries: character plus status.
// - Each received entry carries break, framing, parity and overrun flags.
// - Queues can be disabled to single-character holding registers.
// - Modem inputs report current levels only, no change flags.
// - Receiver shares the transmitter's bit-rate clock.
module asu_uart
    import asu_pkg::*;
#(
    parameter int QUEUE_DEPTH = FIFO_DEPTH
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        serial_reference_clock_i,
    input  wire logic        serial_receive_line_i,
    output logic             serial_transmit_line_o,
    input  wire logic [3:0]  modem_status_n_i
);
    initial begin
        if (QUEUE_DEPTH < 2 || QUEUE_DEPTH > 1024) begin
            $error("asu_uart: QUEUE_DEPTH out of range");
        end
    end

    // ==================================================================
    // State
    typedef struct packed {
        logic [2:0]      rx_sync;
        logic            rx_f;
        logic [2:0]      ref_sync;
        logic            ref_f;
        logic [3:0][2:0] mdm_sync;
        logic [3:0]      mdm_f;
        logic [21:0]     acc;
        logic            tick;
        logic [15:0]     ibrd;
        logic [5:0]      fbrd;
        logic [7:0]      lcr;
        logic [4:0]      ctrl;
        logic [7:0]      xon;
        logic [7:0]      xoff;
        logic            ack;
        logic [31:0]     dat;
        asu_tx_state_t   tx_st;
        logic [3:0]      tx_os;
        logic [2:0]      tx_bit;
        logic            tx_stop2nd;
        logic [7:0]      tx_sh;
        logic            tx_par;
        logic            tx_line;
        asu_rx_state_t   rx_st;
        logic [3:0]      rx_os;
        logic [2:0]      rx_bit;
        logic [7:0]      rx_sh;
        logic            rx_par;
        logic            rx_zero;
        logic            ovr_pend;
        logic            paused;
    } asu_state_t;

    asu_state_t st;
    asu_state_t next_st;

    logic [7:0]          txq_data;
    logic                txq_full;
    logic                txq_empty;
    logic                txq_pop;
    logic                txq_push;
    logic [RX_WIDTH-1:0] rxq_data;
    logic [RX_WIDTH-1:0] rxq_wdata;
    logic                rxq_full;
    logic                rxq_empty;
    logic                rxq_pop;
    logic                rxq_push;

    // Transmit queue
    // 64 by 8 queue
    asu_fifo #(.W(TX_WIDTH), .DEPTH(QUEUE_DEPTH)) u_txq (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .single_i    (!st.lcr[LCR_FIFOEN]),
        .push_i      (txq_push),
        .push_data_i (wb_dat_i[7:0]),
        .pop_i       (txq_pop),
        .pop_data_o  (txq_data),
        .full_o      (txq_full),
        .empty_o     (txq_empty)
    );

    // 64 by 12 queue, single mode
    asu_fifo #(.W(RX_WIDTH), .DEPTH(QUEUE_DEPTH)) u_rxq (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .single_i    (!st.lcr[LCR_FIFOEN]),
        .push_i      (rxq_push),
        .push_data_i (rxq_wdata),
        .pop_i       (rxq_pop),
        .pop_data_o  (rxq_data),
        .full_o      (rxq_full),
        .empty_o     (rxq_empty)
    );

    logic [2:0]  nbits_m1;
    logic [3:0]  os_last;
    logic [3:0]  os_half;
    logic [21:0] divisor;
    logic [21:0] acc_sum;
    logic        wb_req;
    logic        tx_run;
    logic [7:0]  rx_char;
    logic        rx_calc_par;
    logic        rx_frm;
    logic        rx_perr;
    logic        rx_brk;
    logic        rx_done;

    assign nbits_m1 = 3'(4) + {1'b0, st.lcr[LCR_WLEN +: 2]};
    assign os_last  = st.ctrl[CTRL_FAST] ? OS_LAST_FAST : OS_LAST_NORM;
    assign os_half  = st.ctrl[CTRL_FAST] ? OS_HALF_FAST : OS_HALF_NORM;
    assign divisor  = {st.ibrd, st.fbrd};
    assign acc_sum  = st.acc + 22'(1 << FRAC_BITS);
    assign wb_req   = wb_cyc_i && wb_stb_i && !st.ack;
    assign tx_run   = st.ctrl[CTRL_EN] && st.ctrl[CTRL_TXEN];
    assign txq_push = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == OFS_DATA);
    assign rxq_pop  = wb_req && !wb_we_i && (wb_adr_i == OFS_DATA);
    // Frame shifted in from the top; realign short characters
    assign rx_char  = st.rx_sh >> (3'd7 - nbits_m1);
    assign rx_calc_par = st.lcr[LCR_STICK] ? !st.lcr[LCR_EVEN] : (^rx_char) ^ !st.lcr[LCR_EVEN];
    assign rx_done  = st.tick && (st.rx_st == RX_STOP) && (st.rx_os == os_last);
    assign rx_frm   = !st.rx_f;
    assign rx_perr  = st.lcr[LCR_PEN] && (st.rx_par != rx_calc_par);
    // break: data, parity and stop all low
    assign rx_brk   = st.rx_zero && !st.rx_f && !(st.lcr[LCR_PEN] && st.rx_par);
    assign rxq_wdata = {st.ovr_pend, rx_brk, rx_perr && !rx_brk, rx_frm && !rx_brk, rx_char};
    // pause and resume characters are consumed, not queued
    assign rxq_push = rx_done && !rxq_full
                   && !(st.ctrl[CTRL_FLOW] && !rx_frm && (rx_char == st.xon || rx_char == st.xoff));
    assign txq_pop  = (st.tx_st == TX_IDLE) && tx_run && !txq_empty && !st.paused && !st.lcr[LCR_BREAK];

    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;

        // ==================================================================
        // Synchronisers: three stages, change taken when last two agree
        next_st.rx_sync  = {st.rx_sync[1:0], serial_receive_line_i};
        next_st.ref_sync = {st.ref_sync[1:0], serial_reference_clock_i};
        if (st.rx_sync[1] == st.rx_sync[2]) begin
            next_st.rx_f = st.rx_sync[2];
        end
        if (st.ref_sync[1] == st.ref_sync[2]) begin
            next_st.ref_f = st.ref_sync[2];
        end
        for (int i = 0; i < 4; i++) begin
            next_st.mdm_sync[i] = {st.mdm_sync[i][1:0], modem_status_n_i[i]};
            if (st.mdm_sync[i][1] == st.mdm_sync[i][2]) begin
                next_st.mdm_f[i] = st.mdm_sync[i][2];
            end
        end

        // ==================================================================
        // Fractional divider, one oversample tick per divisor/64 ref edges
        // fractional baud
        if (next_st.ref_f && !st.ref_f && divisor != '0) begin
            if (acc_sum >= divisor) begin
                next_st.acc  = acc_sum - divisor;
                next_st.tick = 1'b1;
            end else begin
                next_st.acc = acc_sum;
            end
        end

        // ==================================================================
        // Wishbone slave: ack one cycle after the strobe, every address answered
        next_st.ack = wb_req;
        if (wb_req) begin
            next_st.dat = '0;
            if (wb_we_i) begin
                if (wb_sel_i[0]) begin
                    case (wb_adr_i)
                        OFS_IBRD: next_st.ibrd[7:0] = wb_dat_i[7:0];
                        OFS_FBRD: next_st.fbrd      = wb_dat_i[5:0];
                        OFS_LCR:  next_st.lcr       = wb_dat_i[7:0];
                        OFS_CTRL: next_st.ctrl      = wb_dat_i[4:0];
                        OFS_XON:  next_st.xon       = wb_dat_i[7:0];
                        OFS_XOFF: next_st.xoff      = wb_dat_i[7:0];
                        default:  next_st.ctrl      = st.ctrl;
                    endcase
                end
                if (wb_sel_i[1] && wb_adr_i == OFS_IBRD) begin
                    next_st.ibrd[15:8] = wb_dat_i[15:8];
                end
            end else begin
                case (wb_adr_i)
                    OFS_DATA:   next_st.dat = rxq_empty ? '0 : {20'h00000, rxq_data};
                    OFS_STATUS: next_st.dat = {20'h00000, ~st.mdm_f, st.ovr_pend, st.paused,
                                               st.rx_st != RX_IDLE, st.tx_st != TX_IDLE,
                                               rxq_empty, rxq_full, txq_empty, txq_full};
                    OFS_IBRD:   next_st.dat = {16'h0000, st.ibrd};
                    OFS_FBRD:   next_st.dat = {26'h0000000, st.fbrd};
                    OFS_LCR:    next_st.dat = {24'h000000, st.lcr};
                    OFS_CTRL:   next_st.dat = {27'h0000000, st.ctrl};
                    OFS_XON:    next_st.dat = {24'h000000, st.xon};
                    OFS_XOFF:   next_st.dat = {24'h000000, st.xoff};
                    default:    next_st.dat = '0;
                endcase
            end
        end

        // ==================================================================
        // Transmitter
        if (st.tick && st.tx_st != TX_IDLE) begin
            next_st.tx_os = (st.tx_os == os_last) ? 4'h0 : st.tx_os + 4'h1;
        end
        case (st.tx_st)
            TX_IDLE: begin
                if (txq_pop) begin
                    next_st.tx_st      = TX_START;
                    next_st.tx_os      = 4'h0;
                    next_st.tx_sh      = txq_data;
                    next_st.tx_bit     = 3'h0;
                    next_st.tx_stop2nd = 1'b0;
                    next_st.tx_par = st.lcr[LCR_STICK] ? !st.lcr[LCR_EVEN]
                                   : (^(txq_data & (8'hFF >> (3'd7 - nbits_m1)))) ^ !st.lcr[LCR_EVEN];
                end
            end
            TX_START: begin
                if (st.tick && st.tx_os == os_last) begin
                    next_st.tx_st = TX_DATA;
                end
            end
            TX_DATA: begin
                if (st.tick && st.tx_os == os_last) begin
                    next_st.tx_sh  = st.tx_sh >> 1;
                    next_st.tx_bit = st.tx_bit + 3'h1;
                    if (st.tx_bit == nbits_m1) begin
                        next_st.tx_st = st.lcr[LCR_PEN] ? TX_PAR : TX_STOP;
                    end
                end
            end
            TX_PAR: begin
                if (st.tick && st.tx_os == os_last) begin
                    next_st.tx_st = TX_STOP;
                end
            end
            TX_STOP: begin
                if (st.tick && st.tx_os == os_last) begin
                    if (st.lcr[LCR_STOP2] && !st.tx_stop2nd) begin
                        next_st.tx_stop2nd = 1'b1;
                    end else begin
                        next_st.tx_st = TX_IDLE;
                    end
                end
            end
            default: next_st.tx_st = TX_IDLE;
        endcase
        case (next_st.tx_st)
            TX_START: next_st.tx_line = 1'b0;
            TX_DATA:  next_st.tx_line = next_st.tx_sh[0];
            TX_PAR:   next_st.tx_line = next_st.tx_par;
            default:  next_st.tx_line = 1'b1;
        endcase
        if (next_st.lcr[LCR_BREAK]) begin
            next_st.tx_line = 1'b0;
        end

        // ==================================================================
        // Receiver, timed by the same oversample tick as the transmitter
        // shared bit clock
        if (st.tick && st.rx_st != RX_IDLE && st.rx_st != RX_WAIT) begin
            next_st.rx_os = (st.rx_os == os_last) ? 4'h0 : st.rx_os + 4'h1;
        end
        case (st.rx_st)
            RX_IDLE: begin
                if (st.ctrl[CTRL_EN] && st.ctrl[CTRL_RXEN] && !st.rx_f) begin
                    next_st.rx_st = RX_START;
                    next_st.rx_os = 4'h0;
                end
            end
            RX_START: begin
                if (st.tick && st.rx_os == os_half) begin
                    if (st.rx_f) begin
                        next_st.rx_st = RX_IDLE;
                        next_st.rx_os = 4'h0;
                    end else begin
                        next_st.rx_st   = RX_DATA;
                        next_st.rx_os   = 4'h0;
                        next_st.rx_bit  = 3'h0;
                        next_st.rx_zero = 1'b1;
                    end
                end
            end
            RX_DATA: begin
                if (st.tick && st.rx_os == os_last) begin
                    next_st.rx_sh   = {st.rx_f, st.rx_sh[7:1]};
                    next_st.rx_zero = st.rx_zero && !st.rx_f;
                    next_st.rx_bit  = st.rx_bit + 3'h1;
                    if (st.rx_bit == nbits_m1) begin
                        next_st.rx_st = st.lcr[LCR_PEN] ? RX_PAR : RX_STOP;
                    end
                end
            end
            RX_PAR: begin
                if (st.tick && st.rx_os == os_last) begin
                    next_st.rx_par = st.rx_f;
                    next_st.rx_st  = RX_STOP;
                end
            end
            RX_STOP: begin
                if (rx_done) begin
                    next_st.rx_st = rx_brk ? RX_WAIT : RX_IDLE;
                end
            end
            RX_WAIT: begin
                if (st.rx_f) begin
                    next_st.rx_st = RX_IDLE;
                end
            end
            default: next_st.rx_st = RX_IDLE;
        endcase

        // overrun rides on the next stored character; a new loss wins
        if (rxq_push) begin
            next_st.ovr_pend = 1'b0;
        end
        if (rx_done && rxq_full) begin
            next_st.ovr_pend = 1'b1;
        end
        if (rx_done && st.ctrl[CTRL_FLOW] && !rx_frm) begin
            if (rx_char == st.xoff) begin
                next_st.paused = 1'b1;
            end else if (rx_char == st.xon) begin
                next_st.paused = 1'b0;
            end
        end
        if (!st.ctrl[CTRL_FLOW]) begin
            next_st.paused = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st          <= '0;
            st.rx_sync  <= 3'h7;
            st.rx_f     <= 1'b1;
            st.mdm_sync <= '1;
            st.mdm_f    <= 4'hF;
            st.ibrd     <= IBRD_RST;
            st.fbrd     <= FBRD_RST;
            st.lcr      <= LCR_RST;
            st.ctrl     <= CTRL_RST;
            st.xon      <= XON_RST;
            st.xoff     <= XOFF_RST;
            st.tx_st    <= TX_IDLE;
            st.rx_st    <= RX_IDLE;
            st.tx_line  <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign wb_ack_o               = st.ack;
    assign wb_dat_o               = st.dat;
    assign serial_transmit_line_o = st.tx_line;

    // ==================================================================
    // Assertions
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_tx_launch;
        st.tx_st == TX_IDLE && txq_pop;
    endsequence
    sequence s_rx_false_start;
        st.rx_st == RX_START && st.tick && st.rx_os == os_half && st.rx_f;
    endsequence

    AST_TX_START_LOW: assert property (s_tx_launch |=> !serial_transmit_line_o)
        else $error("start bit not driven low");
    AST_FALSE_START: assert property (s_rx_false_start |=> st.rx_st == RX_IDLE ##1 !rxq_push)
        else $error("false start not dropped");
    AST_BREAK_DRIVE: assert property (st.lcr[LCR_BREAK] && $past(st.lcr[LCR_BREAK]) |-> !serial_transmit_line_o)
        else $error("break not driving line low");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held over two cycles");
    AST_OS_RANGE: assert property (st.tx_os <= os_last && st.rx_os <= os_last)
        else $error("oversample count past limit");
    AST_STOP_HIGH: assert property (st.tx_st == TX_STOP && !st.lcr[LCR_BREAK] |-> serial_transmit_line_o)
        else $error("stop bit not high");
    AST_SINGLE_HOLD: assert property (!st.lcr[LCR_FIFOEN] && rxq_push |=> rxq_full || st.lcr[LCR_FIFOEN])
        else $error("single mode holding register not full after store");
    AST_PAUSE_SET: assert property (rx_done && st.ctrl[CTRL_FLOW] && !rx_frm && rx_char == st.xoff
                                    |=> st.paused ##1 !txq_pop)
        else $error("pause character ignored");
    AST_OVR_FLAG: assert property (rx_done && rxq_full |=> st.ovr_pend)
        else $error("overrun not recorded");
    AST_PAR_LINE: assert property (st.tx_st == TX_PAR && !st.lcr[LCR_BREAK] |-> serial_transmit_line_o == st.tx_par)
        else $error("parity bit wrong on line");

endmodule

// ===== logic/asu_pkg.sv
package asu_pkg;

    // ==================================================================
    // Register byte offsets
    localparam logic [4:0] OFS_DATA   = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h04;
    localparam logic [4:0] OFS_IBRD   = 5'h08;
    localparam logic [4:0] OFS_FBRD   = 5'h0C;
    localparam logic [4:0] OFS_LCR    = 5'h10;
    localparam logic [4:0] OFS_CTRL   = 5'h14;
    localparam logic [4:0] OFS_XON    = 5'h18;
    localparam logic [4:0] OFS_XOFF   = 5'h1C;

    // ==================================================================
    // Field positions
    localparam int LCR_WLEN   = 0;  // 2 bits: data length minus five
    localparam int LCR_PEN    = 2;
    localparam int LCR_EVEN   = 3;
    localparam int LCR_STICK  = 4;
    localparam int LCR_STOP2  = 5;
    localparam int LCR_FIFOEN = 6;
    localparam int LCR_BREAK  = 7;
    localparam int CTRL_EN    = 0;
    localparam int CTRL_TXEN  = 1;
    localparam int CTRL_RXEN  = 2;
    localparam int CTRL_FAST  = 3;
    localparam int CTRL_FLOW  = 4;
    localparam int RXW_FRM    = 8;
    localparam int RXW_PAR    = 9;
    localparam int RXW_BRK    = 10;
    localparam int RXW_OVR    = 11;

    // ==================================================================
    // Reset values
    localparam logic [15:0] IBRD_RST = 16'h0001;
    localparam logic [5:0]  FBRD_RST = 6'h00;
    localparam logic [7:0]  LCR_RST  = 8'h43;
    localparam logic [4:0]  CTRL_RST = 5'h00;
    localparam logic [7:0]  XON_RST  = 8'h11;
    localparam logic [7:0]  XOFF_RST = 8'h13;

    // ==================================================================
    // Sizes and timing counts
    localparam int FIFO_DEPTH     = 64;
    localparam int TX_WIDTH       = 8;
    localparam int RX_WIDTH       = 12;
    localparam int FRAC_BITS      = 6;
    localparam int OVERSAMPLE     = 16;
    localparam int OVERSAMPLE_FST = 8;
    localparam logic [3:0] OS_LAST_NORM = 4'(OVERSAMPLE - 1);
    localparam logic [3:0] OS_LAST_FAST = 4'(OVERSAMPLE_FST - 1);
    localparam logic [3:0] OS_HALF_NORM = 4'(OVERSAMPLE / 2 - 1);
    localparam logic [3:0] OS_HALF_FAST = 4'(OVERSAMPLE_FST / 2 - 1);

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} asu_tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_WAIT} asu_rx_state_t;

endpackage

// ===== logic/asu_fifo.sv
`timescale 1ns/10ps
module asu_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 64
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    input  wire logic         single_i,
    input  wire logic         push_i,
    input  wire logic [W-1:0] push_data_i,
    input  wire logic         pop_i,
    output logic      [W-1:0] pop_data_o,
    output logic              full_o,
    output logic              empty_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("asu_fifo: DEPTH must be a power of two, at least 2");
        end
    end

    typedef struct packed {
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [CW-1:0] count;
    } asu_fifo_state_t;

    asu_fifo_state_t st;
    asu_fifo_state_t next_st;
    logic [W-1:0]    mem [DEPTH];
    logic            do_push;
    logic            do_pop;

    // Single mode limits the queue to one held character
    assign full_o     = single_i ? (st.count != '0) : (st.count == CW'(DEPTH));
    assign empty_o    = (st.count == '0);
    assign do_push    = push_i && !full_o;
    assign do_pop     = pop_i && !empty_o;
    assign pop_data_o = mem[st.rptr];

    always_comb begin
        next_st = st;
        if (do_push) begin
            next_st.wptr = st.wptr + 1'b1;
        end
        if (do_pop) begin
            next_st.rptr = st.rptr + 1'b1;
        end
        next_st.count = st.count + CW'(do_push) - CW'(do_pop);
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (do_push) begin
            mem[st.wptr] <= push_data_i;
        end
    end

endmodule

// ===== tb/asu_partner.sv
`timescale 1ns/10ps
module asu_partner (
    input  wire logic mclk_i,
    input  wire logic tx_i,
    output logic      rx_o = 1'b1
);
    task automatic send(input int n, input logic [15:0] f, input int bl);
        for (int i = 0; i < n; i++) begin
            rx_o <= f[i];
            repeat (bl) @(posedge mclk_i);
        end
        rx_o <= 1'b1;
        @(posedge mclk_i);
    endtask
    task automatic recv(input int n, input int bl, output logic [15:0] f);
        f = 16'h0000;
        @(negedge tx_i);
        repeat (bl / 2) @(posedge mclk_i);
        for (int i = 0; i < n; i++) begin
            f[i] = tx_i;
            repeat (bl) @(posedge mclk_i);
        end
    endtask
endmodule

// ===== tb/asu_uart_test.sv
`timescale 1ns/10ps
module asu_uart_test
    import asu_pkg::*;
;
    logic        mclk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, ack, txl, rxl;
    logic [15:0] ev, v;
    logic [37:0] req = 38'h0;
    logic [31:0] rdat, r, lfsr = 32'h0001848D;
    logic [7:0]  dm;
    int          errors = 0, n_checks = 0, rc = 0, c, bl, n;
    always #5 mclk_i = ~mclk_i;
    // Reference at mclk/8 stays well under the input filter limit
    always @(posedge mclk_i) rc <= rc + 1;
    asu_uart u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(req[37]),
        .wb_adr_i(req[36:32]), .wb_sel_i(4'hF), .wb_dat_i(req[31:0]), .wb_dat_o(rdat), .wb_ack_o(ack),
        .serial_reference_clock_i(rc[2]), .serial_receive_line_i(rxl), .serial_transmit_line_o(txl), .modem_status_n_i(4'h5));
    asu_partner u_p (.mclk_i(mclk_i), .tx_i(txl), .rx_o(rxl));
    // ========================================
    // Helpers
    task automatic chk(input string s, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        req <= {w, a, d};
        do @(posedge mclk_i); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        @(posedge mclk_i);
    endtask
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] frm(input int i);
        c = n + 2 + (i > 0) + i % 2;
        return ((16'hFFFF << (n + 1 + (i > 0))) | {7'h00, dm, 1'b0}
            | (16'(i > 0 && (i == 3 || (^dm ^ (i == 1)))) << (n + 1))) & ~(16'hFFFF << c);
    endfunction
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge mclk_i);
        errors++;
        wrap_up;
    end
    initial begin
        repeat (20) @(posedge mclk_i);
        rst_i <= 1'b0;
        // Modem levels need the synchroniser latency before status shows them
        repeat (4) @(posedge mclk_i);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk("status", 32'h00000A0A, r);
        wb(1'b0, 5'h1E, 32'h0);
        chk("unmapped", 32'h0, r);
        for (int i = 0; i < 4; i++) begin
            bl = 64 << i % 2;
            n = 5 + i;
            lfsr = nxt(lfsr);
            dm = lfsr[7:0] & ~(8'hFF << n);
            ev = frm(i);
            wb(1'b1, OFS_LCR, {25'h0, 1'b1, i[0], i == 3, i == 2, i > 0, i[1:0]});
            wb(1'b1, OFS_CTRL, {28'h0, ~i[0], 3'h7});
            fork
                wb(1'b1, OFS_DATA, {24'h0, dm});
                u_p.recv(c, bl, v);
            join
            chk("frame", ev, v);
            u_p.send(c, i == 1 ? ev ^ (16'h1 << (n + 1)) : ev, bl);
            repeat (bl) @(posedge mclk_i);
            wb(1'b0, OFS_DATA, 32'h0);
            chk("rx char", {22'h0, i == 1, 1'b0, dm}, r);
        end
        u_p.send(1, 16'h0, 32);
        repeat (bl) @(posedge mclk_i);
        u_p.send(16, 16'h0, bl);
        repeat (bl) @(posedge mclk_i);
        wb(1'b0, OFS_DATA, 32'h0);
        chk("break", 32'h00000400, r);
        // Pause character holds a queued byte back, resume lets it out
        wb(1'b1, OFS_CTRL, 32'h00000017);
        dm = XOFF_RST;
        ev = frm(3);
        u_p.send(c, ev, bl);
        lfsr = nxt(lfsr);
        wb(1'b1, OFS_DATA, {24'h0, lfsr[7:0]});
        repeat (bl) @(posedge mclk_i);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk("paused", 32'h00000A48, r);
        dm = XON_RST;
        ev = frm(3);
        fork
            u_p.send(c, ev, bl);
            u_p.recv(c, bl, v);
        join
        dm = lfsr[7:0];
        ev = frm(3);
        chk("resumed", ev, v);
        wb(1'b0, OFS_DATA, 32'h0);
        chk("flow chars", 32'h0, r);
        // Break on the line, queues off: second byte overruns the holding register
        wb(1'b1, OFS_LCR, 32'h0000008F);
        chk("break line", 32'h0, {31'h0, txl});
        for (int k = 0; k < 3; k++) begin
            lfsr = nxt(lfsr);
            dm = lfsr[7:0] | 8'h80;
            ev = frm(2);
            u_p.send(c, ev, bl);
            repeat (bl) @(posedge mclk_i);
            if (k == 0) begin
                v = {8'h00, dm};
            end else begin
                wb(1'b0, OFS_DATA, 32'h0);
                chk("single", {20'h0, k == 2, 3'h0, k == 1 ? v[7:0] : dm}, r);
            end
        end
        wrap_up;
    end
endmodule
